/* common/clock_mode_consts.vh */
// Constants for the clock mode selection and synthesizer register block
`ifndef CLOCK_MODE_CONSTS_VH
`define CLOCK_MODE_CONSTS_VH

// ************************************************************
// Register byte offsets from the peripheral base address
// ************************************************************
`define OFF_SYNTH_CONTROL 24'h120000
`define OFF_SYNTH_STATUS 24'h120004
`define OFF_RESET_CTRL 24'h120008

// ************************************************************
// Bus geometry
// ************************************************************
`define ADDR_W 24
`define DATA_W 32
`define BE_W 4

// ************************************************************
// Clock mode encodings on the mode select pins
// ************************************************************
`define MODE_BYPASS 2'h0
`define MODE_ONE_TO_ONE 2'h1
`define MODE_NORMAL_EXT 2'h2
`define MODE_NORMAL_OSC_DRIVE_OUT 2'h3

// ************************************************************
// Synthesizer control fields
// ************************************************************
`define CTL_MFD_HI 26
`define CTL_MFD_LO 24
`define CTL_RFD_HI 21
`define CTL_RFD_LO 19
`define CTL_CLOCK_OUTPUT_DISABLE_BIT 12
`define CTL_DEPTH_HI 11
`define CTL_DEPTH_LO 10
`define CTL_WR_MASK 32'h07381c00
`define CTL_RESET 32'h00000000

// ************************************************************
// Synthesizer status fields
// ************************************************************
`define STS_MODE 7
`define STS_SEL 6
`define STS_REF 5
`define STS_LOCK 3
`define STS_ACCERR 2

// ************************************************************
// Reset control fields
// ************************************************************
`define RCR_FRCRST 7
`define RCR_ACCERR_CLR 0

// ************************************************************
// Multiplier arithmetic and timing
// ************************************************************
`define MULT_W 5
`define MULT_BYPASS 5'h01
`define MULT_ONE_TO_ONE 5'h02
`define MULT_NORMAL_BASE 5'h04
`define RFD_NONE 3'h0
`define DEPTH_NONE 2'h0
`define CLK_PERIOD_NS 50
`define LOCK_TIME_NS 10000
`define LOCK_CNT_W 8

`endif

/* verilog/pin_sync3.v */
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
`default_nettype none

module pin_sync3 #(
   parameter WIDTH = 2
) (
   input wire clk,
   input wire reset_n,
   input wire [WIDTH-1:0] pin,
   output reg [WIDTH-1:0] value_q
);

   reg [WIDTH-1:0] s1_q;
   reg [WIDTH-1:0] s2_q;
   reg [WIDTH-1:0] s3_q;
   genvar i;

   // Chain runs in reset too so straps can be sampled
   always @(posedge clk) begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end

   // ************************************************************
   // Per bit agreement of second and third stage
   // ************************************************************
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge clk) begin
            if (s2_q[i] == s3_q[i]) begin
               value_q[i] <= s3_q[i];
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

/* verilog/bus_clock_div.v */
// Divide-by-two bus clock generator with output gate
`timescale 1ns/100ps
`default_nettype none

module bus_clock_div (
   input wire clk,
   input wire reset_n,
   input wire enable,
   output reg clk_out_q
);

   reg phase_q;

   // Free running phase, gated copy to the pin
   always @(posedge clk) begin
      if (!reset_n) begin
         phase_q <= 1'b0;
         clk_out_q <= 1'b0;
      end else begin
         phase_q <= ~phase_q;
         clk_out_q <= enable ? ~phase_q : 1'b0;
      end
   end

endmodule

`default_nettype wire

/* verilog/clock_mode_synth.v */
// Clock mode selection, synthesizer registers and clock pins
//
// How it works
// - Drive oscillator pin toward external crystal
// - Bus clock shown on bus clock pin
// - Mode chosen in reset, shown in status
// - Mode frozen after reset, pins ignored
// - Decode 00 bypass,01 1:1,10 ext,11 crystal
// - 1:1 mode core clock twice reference
// - Reset output follows internal system reset
// - Force bit also asserts reset output
// - Control register at 0x12_0000
// - Status register at 0x12_0004
// - Both registers supervisor access only
// - Multiplier field bits 26..24 sets feedback
// - 1:1 mode skips post divider, no modulation
// - Normal modes multiply 4x to 18x
// - Bus clock on after reset, disable bit
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "clock_mode_consts.vh"

module clock_mode_synth #(
   parameter LOCK_CYCLES = (`LOCK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   input wire clk,
   input wire reset_n,
   input wire ref_clock_in,
   input wire [1:0] mode_select_pins,
   output reg osc_drive_out,
   output wire bus_clock_out,
   output reg reset_output_pin,
   input wire [`ADDR_W-1:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [`DATA_W-1:0] avs_writedata,
   input wire [`BE_W-1:0] avs_byteenable,
   input wire avs_supervisor,
   output reg [`DATA_W-1:0] avs_readdata,
   output reg avs_waitrequest,
   output reg [1:0] clock_mode_q,
   output reg [`MULT_W-1:0] core_mult_q,
   output reg [2:0] post_div_q,
   output reg [1:0] mod_depth_q,
   output reg pll_locked_q
);

   // ************************************************************
   // Declarations
   // ************************************************************
   wire [1:0] mode_pins_s;
   wire [0:0] ref_s;
   reg [1:0] mode_q;
   reg [`DATA_W-1:0] ctl_q;
   reg [`DATA_W-1:0] ctl_d;
   reg frc_rst_q;
   reg acc_err_q;
   reg [`LOCK_CNT_W-1:0] lock_cnt_q;
   reg [2:0] mfd_prev_q;
   reg clock_output_disable_bit_q;
   reg ack_q;
   wire req;
   wire take;
   wire hit_ctl;
   wire hit_sts;
   wire hit_rcr;
   wire priv_ok;
   wire wr_ctl;
   wire wr_rcr;
   wire [`DATA_W-1:0] be_mask;
   wire [`DATA_W-1:0] sts_word;
   wire [`DATA_W-1:0] rcr_word;
   wire [2:0] mult_factor_field;
   wire normal_mode;
   wire [`LOCK_CNT_W-1:0] lock_max;
   reg [`DATA_W-1:0] rd_d;
   reg [`MULT_W-1:0] mult_d;
   genvar b;

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   // Mode straps pass three stages with agreement filter
   pin_sync3 #(
      .WIDTH(2)
   ) u_mode_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin(mode_select_pins),
      .value_q(mode_pins_s)
   );

   // Reference pin sampled for the oscillator drive
   pin_sync3 #(
      .WIDTH(1)
   ) u_ref_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin(ref_clock_in),
      .value_q(ref_s)
   );

   // ************************************************************
   // Clock mode capture
   // ************************************************************
   // Tracks the straps while reset is held, then freezes
   always @(posedge clk) begin
      if (!reset_n) begin
         mode_q <= mode_pins_s;
      end else begin
         mode_q <= mode_q;
      end
   end

   // Normal mode decode used only by the post divider and depth outputs
   assign normal_mode = mode_q[1];
   assign mult_factor_field = ctl_q[`CTL_MFD_HI:`CTL_MFD_LO];

   // Effective multiplier of the reference frequency
   always @* begin
      case (mode_q)
         `MODE_BYPASS: begin
            mult_d = `MULT_BYPASS;
         end
         `MODE_ONE_TO_ONE: begin
            mult_d = `MULT_ONE_TO_ONE;
         end
         `MODE_NORMAL_EXT, `MODE_NORMAL_OSC_DRIVE_OUT: begin
            mult_d = `MULT_NORMAL_BASE + {1'b0, mult_factor_field, 1'b0};
         end
         default: begin
            mult_d = `MULT_BYPASS;
         end
      endcase
   end

   // Synthesizer outputs, post divider and modulation only in normal
   always @(posedge clk) begin
      if (!reset_n) begin
         clock_mode_q <= `MODE_BYPASS;
         core_mult_q <= `MULT_BYPASS;
         post_div_q <= `RFD_NONE;
         mod_depth_q <= `DEPTH_NONE;
      end else begin
         clock_mode_q <= mode_q;
         core_mult_q <= mult_d;
         if (normal_mode) begin
            post_div_q <= ctl_q[`CTL_RFD_HI:`CTL_RFD_LO];
            mod_depth_q <= ctl_q[`CTL_DEPTH_HI:`CTL_DEPTH_LO];
         end else begin
            post_div_q <= `RFD_NONE;
            mod_depth_q <= `DEPTH_NONE;
         end
      end
   end

   // ************************************************************
   // Lock indication
   // ************************************************************
   assign lock_max = LOCK_CYCLES[`LOCK_CNT_W-1:0];

   // Relock period after reset or a multiplier change
   always @(posedge clk) begin
      if (!reset_n) begin
         lock_cnt_q <= {`LOCK_CNT_W{1'b0}};
         pll_locked_q <= 1'b0;
         mfd_prev_q <= 3'h0;
      end else begin
         mfd_prev_q <= mult_factor_field;
         if (mult_factor_field != mfd_prev_q) begin
            lock_cnt_q <= {`LOCK_CNT_W{1'b0}};
            pll_locked_q <= 1'b0;
         end else if (lock_cnt_q == lock_max) begin
            pll_locked_q <= 1'b1;
         end else begin
            lock_cnt_q <= lock_cnt_q + 1'b1;
         end
      end
   end

   // ************************************************************
   // Clock and reset pins
   // ************************************************************
   // Bus clock runs at half the core rate, gated by disable bit
   bus_clock_div u_bus_clk (
      .clk(clk),
      .reset_n(reset_n),
      .enable(~clock_output_disable_bit_q),
      .clk_out_q(bus_clock_out)
   );

   // Oscillator drive inverts the reference only with a crystal
   always @(posedge clk) begin
      if (!reset_n) begin
         osc_drive_out <= 1'b0;
      end else if (mode_q == `MODE_NORMAL_OSC_DRIVE_OUT) begin
         osc_drive_out <= ~ref_s[0];
      end else begin
         osc_drive_out <= 1'b0;
      end
   end

   // Reset output from system reset or software force
   always @(posedge clk) begin
      if (!reset_n) begin
         reset_output_pin <= 1'b1;
      end else begin
         reset_output_pin <= frc_rst_q;
      end
   end

   // ************************************************************
   // Bus decode
   // ************************************************************
   assign req = avs_read | avs_write;
   assign take = req & ack_q;
   assign hit_ctl = (avs_address == `OFF_SYNTH_CONTROL);
   assign hit_sts = (avs_address == `OFF_SYNTH_STATUS);
   assign hit_rcr = (avs_address == `OFF_RESET_CTRL);
   assign priv_ok = avs_supervisor;
   assign wr_ctl = take & avs_write & hit_ctl & priv_ok;
   assign wr_rcr = take & avs_write & hit_rcr & priv_ok;

   // Byte enables widened to a bit mask
   generate
      for (b = 0; b < `BE_W; b = b + 1) begin : g_be
         assign be_mask[b*8+7:b*8] = {8{avs_byteenable[b]}};
      end
   endgenerate

   // One wait state on every access, released for one cycle
   always @(posedge clk) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
         avs_waitrequest <= 1'b1;
      end else if (req & ~ack_q) begin
         ack_q <= 1'b1;
         avs_waitrequest <= 1'b0;
      end else begin
         ack_q <= 1'b0;
         avs_waitrequest <= 1'b1;
      end
   end

   // ************************************************************
   // Register writes
   // ************************************************************
   // Only writable fields change, reserved bits stay zero
   always @* begin
      ctl_d = (ctl_q & ~(be_mask & `CTL_WR_MASK)) | (avs_writedata & be_mask & `CTL_WR_MASK);
   end

   // Control register and its disable bit copy
   always @(posedge clk) begin
      if (!reset_n) begin
         ctl_q <= `CTL_RESET;
         clock_output_disable_bit_q <= 1'b0;
      end else begin
         if (wr_ctl) begin
            ctl_q <= ctl_d;
         end
         clock_output_disable_bit_q <= ctl_q[`CTL_CLOCK_OUTPUT_DISABLE_BIT];
      end
   end

   // Reset control register force bit
   always @(posedge clk) begin
      if (!reset_n) begin
         frc_rst_q <= 1'b0;
      end else if (wr_rcr & avs_byteenable[0]) begin
         frc_rst_q <= avs_writedata[`RCR_FRCRST];
      end
   end

   // Sticky flag for user mode access, set wins over clear
   always @(posedge clk) begin
      if (!reset_n) begin
         acc_err_q <= 1'b0;
      end else if (take & ~priv_ok & (hit_ctl | hit_sts | hit_rcr)) begin
         acc_err_q <= 1'b1;
      end else if (wr_rcr & avs_byteenable[0] & avs_writedata[`RCR_ACCERR_CLR]) begin
         acc_err_q <= 1'b0;
      end
   end

   // ************************************************************
   // Register reads
   // ************************************************************
   // Status word with mode, select, reference, lock, error
   assign sts_word = ({{(`DATA_W-1){1'b0}}, (mode_q != `MODE_BYPASS)} << `STS_MODE)
                   | ({{(`DATA_W-1){1'b0}}, mode_q[1]} << `STS_SEL)
                   | ({{(`DATA_W-1){1'b0}}, (mode_q == `MODE_NORMAL_OSC_DRIVE_OUT)} << `STS_REF)
                   | ({{(`DATA_W-1){1'b0}}, pll_locked_q} << `STS_LOCK)
                   | ({{(`DATA_W-1){1'b0}}, acc_err_q} << `STS_ACCERR);

   // Reset control readback
   assign rcr_word = {{(`DATA_W-1){1'b0}}, frc_rst_q} << `RCR_FRCRST;

   // Read mux, user mode and unmapped addresses read zero
   always @* begin
      rd_d = {`DATA_W{1'b0}};
      if (priv_ok) begin
         if (hit_ctl) begin
            rd_d = ctl_q;
         end else if (hit_sts) begin
            rd_d = sts_word;
         end else if (hit_rcr) begin
            rd_d = rcr_word;
         end
      end
   end

   // Read data loaded with the release of waitrequest
   always @(posedge clk) begin
      if (!reset_n) begin
         avs_readdata <= {`DATA_W{1'b0}};
      end else if (avs_read & ~ack_q) begin
         avs_readdata <= rd_d;
      end
   end

endmodule

`default_nettype wire

/* testbench/clock_mode_synth_assertions.sv */
// Port checker for the clock mode and synthesizer block
`timescale 1ns/100ps
`default_nettype none
module clock_mode_synth_assertions (
   input wire clk,
   input wire reset_n,
   input wire osc_drive_out,
   input wire bus_clock_out,
   input wire reset_output_pin,
   input wire [23:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire avs_supervisor,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire [1:0] clock_mode_q,
   input wire [4:0] core_mult_q,
   input wire [2:0] post_div_q,
   input wire [1:0] mod_depth_q
);
   // ************************************************************
   // Settle tracking and properties
   // ************************************************************
   logic [1:0] up_q;
   wire up = up_q[1];
   // Two whole cycles since reset release
   always_ff @(posedge clk) up_q <= reset_n ? {up_q[0], 1'b1} : 2'h0;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
   a_wait_one: assert property (s_req |=> s_ans)
      else $error("bus answer not a single wait cycle");
   a_rst_out: assert property (disable iff (1'b0) !reset_n |=> reset_output_pin)
      else $error("reset output low during reset");
   a_mode_hold: assert property (up |-> $stable(clock_mode_q))
      else $error("clock mode moved after reset");
   a_osc_idle: assert property (up && clock_mode_q != 2'h3 |-> !osc_drive_out)
      else $error("oscillator drive active without crystal mode");
   a_byp_mult: assert property (up && clock_mode_q == 2'h0 |-> core_mult_q == 5'h01)
      else $error("bypass multiplier wrong");
   a_one_mult: assert property (up && clock_mode_q == 2'h1 |-> core_mult_q == 5'h02)
      else $error("one to one multiplier wrong");
   a_norm_range: assert property (up && clock_mode_q[1] |-> core_mult_q inside {[4:18]} && !core_mult_q[0])
      else $error("normal multiplier out of range");
   a_no_post: assert property (up && !clock_mode_q[1] |-> post_div_q == 3'h0 && mod_depth_q == 2'h0)
      else $error("post divider or depth active outside normal mode");
   a_user_zero: assert property (avs_read && !avs_waitrequest && !avs_supervisor |-> avs_readdata == 32'h0)
      else $error("user read returned data");
   a_rsvd_zero: assert property (avs_read && !avs_waitrequest && avs_address == 24'h120000
      |-> avs_readdata[31:27] == 5'h0)
      else $error("reserved control bits not zero");
   a_clk_half: assert property (bus_clock_out |=> !bus_clock_out)
      else $error("bus clock high two cycles");
endmodule
bind clock_mode_synth clock_mode_synth_assertions chk (.clk, .reset_n, .osc_drive_out, .bus_clock_out,
   .reset_output_pin, .avs_address, .avs_read, .avs_write, .avs_supervisor, .avs_readdata, .avs_waitrequest,
   .clock_mode_q, .core_mult_q, .post_div_q, .mod_depth_q);
`default_nettype wire

/* testbench/ref_clock_src.sv */
// External reference clock or crystal across the oscillator pins
`timescale 1ns/100ps
`default_nettype none
module ref_clock_src #(
   parameter HALF_NS = 130
) (
   input wire logic osc_drive_out_fit,
   input wire logic osc_drive_out,
   output logic ref_clock_in
);
   logic ext_q = 1'b0;
   logic osc_drive_out_q = 1'b0;
   // Free running external clock
   always #(HALF_NS) ext_q = !ext_q;
   // Crystal hands the drive back with a short lag
   always @(osc_drive_out) osc_drive_out_q <= #7 osc_drive_out;
   // External clock unless a crystal is fitted
   assign ref_clock_in = osc_drive_out_fit ? osc_drive_out_q : ext_q;
endmodule
`default_nettype wire

/* testbench/clock_mode_synth_tb_top.sv */
// Self-checking bench for the clock mode and synthesizer block
`timescale 1ns/100ps
`default_nettype none
`include "clock_mode_consts.vh"
module clock_mode_synth_tb_top;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0] mode_select_pins = 2'h0;
   logic osc_drive_out_fit = 1'b0;
   logic [23:0] avs_address = 24'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic avs_supervisor = 1'b1;
   wire ref_clock_in, osc_drive_out, bus_clock_out, reset_output_pin, avs_waitrequest, pll_locked_q;
   wire [31:0] avs_readdata;
   wire [1:0] clock_mode_q, mod_depth_q;
   wire [4:0] core_mult_q;
   wire [2:0] post_div_q;
   logic [63:0] exp_q[$];
   logic [63:0] e;
   logic [31:0] wd;
   logic [1:0] m;
   int bad_count = 0;
   int cmp_count = 0;
   int edges;
   // ************************************************************
   // Clock, parts and helpers
   // ************************************************************
   initial forever #25 clk = !clk;
   ref_clock_src src (.osc_drive_out_fit, .osc_drive_out, .ref_clock_in);
   clock_mode_synth #(.LOCK_CYCLES(4)) uut (.clk, .reset_n, .ref_clock_in, .mode_select_pins, .osc_drive_out,
      .bus_clock_out, .reset_output_pin, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hf), .avs_supervisor, .avs_readdata, .avs_waitrequest, .clock_mode_q, .core_mult_q,
      .post_div_q, .mod_depth_q, .pll_locked_q);
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // One bus cycle; a read notes its expected word
   task automatic bus(input logic we, input logic [23:0] a, input logic [31:0] d,
      input logic [31:0] msk = 32'hffffffff, input logic sup = 1'b1);
      if (!we) exp_q.push_back({msk, d});
      avs_write <= we;
      avs_read <= !we;
      avs_address <= a;
      avs_writedata <= d;
      avs_supervisor <= sup;
      // Only the watchdog ends a wait that never gets its answer
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   // Changes seen on bus clock or oscillator drive
   task automatic count(input logic osc);
      logic last;
      edges = 0;
      last = osc ? osc_drive_out : bus_clock_out;
      repeat (32) begin
         @(posedge clk);
         if ((osc ? osc_drive_out : bus_clock_out) !== last) edges++;
         last = osc ? osc_drive_out : bus_clock_out;
      end
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Oldest note against each answered read
   always @(posedge clk) begin
      if (reset_n && avs_read && avs_waitrequest === 1'b0) begin
         if (exp_q.size() == 0) chk("rd_extra", 32'h1, 32'h0);
         else begin
            e = exp_q.pop_front();
            chk("rd", avs_readdata & e[63:32], e[31:0] & e[63:32]);
         end
      end
   end
   // Watchdog
   initial begin
      #(4000 * 50);
      bad_count++;
      close_out;
   end
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      void'($urandom(76));
      tick(2);
      reset_n <= 1'b1;
      // Let one edge pass so reset is not driven twice in one step
      tick(1);
      for (int i = 0; i < 4; i++) begin
         m = i[1:0];
         osc_drive_out_fit <= (m == 2'h3);
         mode_select_pins <= m;
         reset_n <= 1'b0;
         tick(6);
         reset_n <= 1'b1;
         tick(3);
         chk("rst_out", reset_output_pin, 1'b0);
         mode_select_pins <= ~m;
         tick(12);
         chk("mode", clock_mode_q, m);
         chk("mult", core_mult_q, m == 0 ? 5'h01 : m == 1 ? 5'h02 : 5'h04);
         bus(0, `OFF_SYNTH_STATUS, {24'h0, m != 0, m[1], m == 3, 5'h0}, 32'he4);
         count(1'b0);
         chk("clk_on", edges != 0, 1'b1);
         count(1'b1);
         chk("osc", edges != 0, m == 3);
         wd = $urandom;
         bus(1, `OFF_SYNTH_CONTROL, wd);
         bus(0, `OFF_SYNTH_CONTROL, wd & `CTL_WR_MASK);
         tick(8);
         chk("mult_new", core_mult_q, m == 0 ? 5'h01 : m == 1 ? 5'h02 : 5'h04 + 2 * wd[26:24]);
         chk("pd", {post_div_q, mod_depth_q}, m[1] ? {wd[21:19], wd[11:10]} : 5'h0);
         if (m[1]) chk("lock", pll_locked_q, 1'b1);
         count(1'b0);
         chk("clk_dis", edges != 0, !wd[12]);
      end
      bus(1, `OFF_SYNTH_CONTROL, ~wd, 32'hffffffff, 1'b0);
      bus(0, `OFF_SYNTH_CONTROL, 32'h0, 32'hffffffff, 1'b0);
      bus(0, `OFF_SYNTH_CONTROL, wd & `CTL_WR_MASK);
      bus(0, `OFF_SYNTH_STATUS, 32'h4, 32'h4);
      bus(1, `OFF_RESET_CTRL, 32'h81);
      tick(3);
      chk("force", reset_output_pin, 1'b1);
      bus(0, `OFF_RESET_CTRL, 32'h80);
      bus(0, `OFF_SYNTH_STATUS, 32'h0, 32'h4);
      bus(0, 24'h120010, 32'h0);
      bus(1, `OFF_RESET_CTRL, 32'h0);
      tick(3);
      chk("unforce", reset_output_pin, 1'b0);
      chk("left", exp_q.size(), 32'h0);
      close_out;
   end
endmodule
`default_nettype wire
